// ### design/ecl_loader.sv
// Purpose: Configuration loader: EEPROM fetch as bus primary, secondary
//          register access, spike filter and completion flag.
// Assumes: 100 MHz clk; bus pins are open drain on one shared bus.
// Notes:   EEPROM byte 0 holds the boost index, byte 1 the flat gain.
`timescale 1ns/1ps

// Summary of operation
// - In primary mode, act as bus primary and read settings from EEPROM.
// - Pull the done output low after a successful EEPROM read.
// - Keep answering the secondary address before, during and after loading.
// - Signal done typically 30 ms after the load request is asserted.
// - Generate the EEPROM serial clock at typically 303 kHz.
// - Accept boost index values 0 through 19.
// - Hold a 3-bit flat-gain selection field.
// - Reject bus spikes up to 50 ns wide.
// - Secondary interface works up to 400 kHz serial clock.
// - Sample address and mode straps only in the first cycle after each reset.
module ecl_loader #(
  parameter int LOAD_CYC = ecl_pkg::LOAD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       mode_primary,
  input  wire logic [2:0] bus_id_strap,
  input  wire logic       load_req_n,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            cfg_done_n,
  output logic            load_failed,
  output logic [4:0]      boost_level_index,
  output logic [2:0]      flat_gain_sel
);

  // ----------------------------------------------------------------------
  // Straps, input synchronisers and spike filter
  // ----------------------------------------------------------------------
  logic       strap_taken_reg;
  logic       prim_reg;
  logic [2:0] id_reg;
  logic [2:0] req_sync_reg;
  logic       req_q_reg;
  wire  [1:0] filt;
  wire  [1:0] raw = {sda_in, scl_in};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_reg <= 1'b0;
      prim_reg        <= 1'b0;
      id_reg          <= 3'h0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      prim_reg        <= mode_primary;
      id_reg          <= bus_id_strap;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync_reg <= 3'h7;
      req_q_reg    <= 1'b1;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], load_req_n};
      if (req_sync_reg[1] == req_sync_reg[2]) begin
        req_q_reg <= req_sync_reg[2];
      end
    end
  end

  // A change is accepted only after it has stood longer than a spike can.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [2:0] sync_reg;
      logic [2:0] cnt_reg;
      logic       lvl_reg;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_reg <= 3'h7;
          cnt_reg  <= 3'h0;
          lvl_reg  <= 1'b1;
        end else begin
          sync_reg <= {sync_reg[1:0], raw[gi]};
          if (sync_reg[1] == sync_reg[2] && sync_reg[2] != lvl_reg) begin
            if (cnt_reg == 3'(ecl_pkg::SPIKE_CYC)) begin
              lvl_reg <= sync_reg[2];
              cnt_reg <= 3'h0;
            end else begin
              cnt_reg <= cnt_reg + 3'h1;
            end
          end else begin
            cnt_reg <= 3'h0;
          end
        end
      end
      assign filt[gi] = lvl_reg;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Secondary responder and register file
  // ----------------------------------------------------------------------
  ecl_sec_if sec ();
  ecl_sec_resp u_resp (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (sec.resp)
  );

  typedef enum logic [2:0] {
    P_IDLE, P_WAIT_BUS, P_RUN, P_BACKOFF, P_DONE, P_FAIL
  } ecl_pst_t;

  ecl_pst_t   pst_reg;
  logic [4:0] boost_reg;
  logic [2:0] flat_reg;
  logic       ok_reg;
  logic       ee_wr_boost;
  logic       ee_wr_flat;
  logic [7:0] rx_reg;

  assign sec.scl      = filt[0];
  assign sec.sda      = filt[1];
  assign sec.dev_addr = {ecl_pkg::SEC_ADDR_HI, id_reg};
  assign sec.rd_data  = (sec.rd_ptr == ecl_pkg::REG_BOOST)  ? {3'h0, boost_reg} :
                        (sec.rd_ptr == ecl_pkg::REG_FLAT)   ? {5'h00, flat_reg} :
                        (sec.rd_ptr == ecl_pkg::REG_STATUS) ?
                          {5'h00, pst_reg == P_FAIL, ok_reg, prim_reg} : 8'h00;

  wire sec_boost = sec.wr_stb && sec.wr_ptr == ecl_pkg::REG_BOOST;
  wire sec_flat  = sec.wr_stb && sec.wr_ptr == ecl_pkg::REG_FLAT;
  wire boost_ok  = (ee_wr_boost ? rx_reg : sec.wr_data) <= {3'h0, ecl_pkg::BOOST_MAX};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_reg <= ecl_pkg::BOOST_RST;
      flat_reg  <= ecl_pkg::FLAT_RST;
    end else begin
      if ((ee_wr_boost || sec_boost) && boost_ok) begin
        boost_reg <= ee_wr_boost ? rx_reg[4:0] : sec.wr_data[4:0];
      end
      if (ee_wr_flat || sec_flat) begin
        flat_reg <= ee_wr_flat ? rx_reg[2:0] : sec.wr_data[2:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // EEPROM primary engine
  // ----------------------------------------------------------------------
  logic [2:0]  tok_reg;
  logic [3:0]  bit_reg;
  logic [1:0]  ph_reg;
  logic [6:0]  div_reg;
  logic [21:0] tmr_reg;
  logic        tmr_done_reg;
  logic        nacked_reg;
  logic        pdrv_reg;
  ecl_pkg::ecl_tok_t kind;
  logic [7:0]  tx_byte;

  always_comb begin
    kind    = ecl_pkg::TK_WR;
    tx_byte = ecl_pkg::EE_WR_ADDR;
    case (tok_reg)
      3'h0, 3'h3: kind = ecl_pkg::TK_START;
      3'h2:    tx_byte = ecl_pkg::EE_OFFSET;
      3'h4:    tx_byte = ecl_pkg::EE_RD_ADDR;
      3'h5:    kind = ecl_pkg::TK_RD_ACK;
      3'h6:    kind = ecl_pkg::TK_RD_NACK;
      3'h7:    kind = ecl_pkg::TK_STOP;
      default: kind = ecl_pkg::TK_WR;
    endcase
  end

  wire running  = (pst_reg == P_RUN);
  wire qtick    = running && div_reg == 7'(ecl_pkg::QTR_CYC - 1);
  wire is_start = (kind == ecl_pkg::TK_START);
  wire is_stop  = (kind == ecl_pkg::TK_STOP);
  wire is_wr    = (kind == ecl_pkg::TK_WR);
  wire is_ack   = (bit_reg == 4'h8);
  wire bit_val  = is_ack ? (kind != ecl_pkg::TK_RD_ACK) :
                  (is_wr ? tx_byte[3'(4'h7 - bit_reg)] : 1'b1);
  wire tok_bits_end = (is_start || is_stop) ? 1'b1 : (bit_reg == ecl_pkg::BYTE_BITS - 4'h1);
  wire scl_low  = (ph_reg < 2'h2);
  wire sda_low  = is_start ? (ph_reg == 2'h3) : is_stop ? (ph_reg != 2'h3) : ~bit_val;
  wire sample   = qtick && ph_reg == 2'h2 && !is_start && !is_stop;
  wire arb_lost = sample && is_wr && !is_ack && bit_val && !filt[1];
  wire ee_nack  = sample && is_wr && is_ack && filt[1];
  wire req_edge = req_sync_reg[2] == req_sync_reg[1] && !req_sync_reg[2] && req_q_reg;
  wire tok_end  = qtick && ph_reg == 2'h3 && tok_bits_end;

  assign ee_wr_boost = tok_end && kind == ecl_pkg::TK_RD_ACK;
  assign ee_wr_flat  = tok_end && kind == ecl_pkg::TK_RD_NACK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pst_reg <= P_IDLE;  tok_reg <= 3'h0; bit_reg <= 4'h0; ph_reg <= 2'h0;
      div_reg <= 7'h00;   rx_reg <= 8'h00; ok_reg <= 1'b0;
      tmr_reg <= 22'h0;   tmr_done_reg <= 1'b0; nacked_reg <= 1'b0; pdrv_reg <= 1'b0;
    end else begin
      div_reg <= (qtick || !running) ? 7'h00 : div_reg + 7'h01;
      if (req_edge && prim_reg) begin
        tmr_reg <= 22'h0; tmr_done_reg <= 1'b0;
      end else if (tmr_reg == 22'(LOAD_CYC - 1)) begin
        tmr_done_reg <= 1'b1;
      end else begin
        tmr_reg <= tmr_reg + 22'h1;
      end
      if (sample && !is_wr && !is_ack) begin
        rx_reg <= {rx_reg[6:0], filt[1]};
      end
      // Data is held through the first quarter so only start and stop move it while the clock is high.
      if (!running) begin
        pdrv_reg <= 1'b0;
      end else if (ph_reg != 2'h0) begin
        pdrv_reg <= sda_low;
      end
      case (pst_reg)
        P_IDLE: begin
          if (req_edge && prim_reg) begin
            pst_reg <= P_WAIT_BUS; ok_reg <= 1'b0;
          end
        end
        P_WAIT_BUS: begin
          if (!sec.busy) begin
            pst_reg <= P_RUN; tok_reg <= 3'h0; bit_reg <= 4'h0; ph_reg <= 2'h0;
            nacked_reg <= 1'b0;
          end
        end
        P_RUN: begin
          if (arb_lost) begin
            pst_reg <= P_BACKOFF;
          end else if (qtick) begin
            ph_reg <= ph_reg + 2'h1;
            if (ee_nack) begin
              nacked_reg <= 1'b1;
            end
            if (tok_end) begin
              bit_reg <= 4'h0;
              tok_reg <= nacked_reg ? ecl_pkg::TOK_LAST : tok_reg + 3'h1;
              if (tok_reg == ecl_pkg::TOK_LAST) begin
                pst_reg <= nacked_reg ? P_FAIL : P_DONE;
                ok_reg  <= !nacked_reg;
              end
            end else if (ph_reg == 2'h3) begin
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        P_BACKOFF: if (!sec.busy) pst_reg <= P_WAIT_BUS;
        P_DONE, P_FAIL: if (req_edge) pst_reg <= P_WAIT_BUS;
        default: pst_reg <= P_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_n <= 1'b1; sda_oe_n <= 1'b1; cfg_done_n <= 1'b1;
      load_failed <= 1'b0; boost_level_index <= ecl_pkg::BOOST_RST;
      flat_gain_sel <= ecl_pkg::FLAT_RST;
    end else begin
      scl_oe_n    <= ~(running && scl_low);
      sda_oe_n    <= ~(pdrv_reg || sec.sda_low);
      cfg_done_n  <= ~(ok_reg && tmr_done_reg && pst_reg == P_DONE);
      load_failed <= (pst_reg == P_FAIL);
      boost_level_index <= boost_reg;
      flat_gain_sel     <= flat_reg;
    end
  end

  // Open-drain pins only ever pull low.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

endmodule // ecl_loader

// ### design/ecl_sec_resp.sv
// Purpose: Secondary bus responder: address match, pointer, writes, reads.
// Assumes: Inputs are synchronised and spike-filtered.
// Notes:   First written byte sets the pointer; the pointer auto-increments.
`timescale 1ns/1ps

module ecl_sec_resp (
  input  wire logic   clk,
  input  wire logic   rst_n,
  ecl_sec_if.resp     bus
);

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WDATA, S_WACK, S_RDATA, S_RACK
  } ecl_sst_t;

  ecl_sst_t   st_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic       rw_reg;
  logic       first_reg;
  logic       nack_reg;
  logic       drv_reg;
  logic       busy_reg;
  logic       stb_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wd_reg;

  wire scl_rise = bus.scl & ~scl_q_reg;
  wire scl_fall = ~bus.scl & scl_q_reg;
  wire start_ev = bus.scl & scl_q_reg & sda_q_reg & ~bus.sda;
  wire stop_ev  = bus.scl & scl_q_reg & ~sda_q_reg & bus.sda;
  wire addr_hit = (sh_reg[7:1] == bus.dev_addr);

  assign bus.sda_low = drv_reg;
  assign bus.busy    = busy_reg;
  assign bus.wr_stb  = stb_reg;
  assign bus.wr_ptr  = ptr_reg;
  assign bus.wr_data = wd_reg;
  assign bus.rd_ptr  = ptr_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;  scl_q_reg <= 1'b1;  sda_q_reg <= 1'b1;
      sh_reg <= 8'h00;   cnt_reg <= 4'h0;    rw_reg <= 1'b0;
      first_reg <= 1'b0; nack_reg <= 1'b0;   drv_reg <= 1'b0;
      busy_reg <= 1'b0;  stb_reg <= 1'b0;    ptr_reg <= 8'h00;
      wd_reg <= 8'h00;
    end else begin
      scl_q_reg <= bus.scl;
      sda_q_reg <= bus.sda;
      stb_reg   <= 1'b0;
      if (start_ev) begin
        st_reg <= S_ADDR; cnt_reg <= 4'h0; drv_reg <= 1'b0; busy_reg <= 1'b1;
      end else if (stop_ev) begin
        st_reg <= S_IDLE; drv_reg <= 1'b0; busy_reg <= 1'b0;
      end else begin
        case (st_reg)
          S_ADDR, S_WDATA: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], bus.sda};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              if (st_reg == S_ADDR) begin
                if (addr_hit) begin
                  st_reg <= S_AACK; drv_reg <= 1'b1; rw_reg <= sh_reg[0];
                  first_reg <= 1'b1;
                end else begin
                  st_reg <= S_IDLE;
                end
              end else begin
                st_reg <= S_WACK; drv_reg <= 1'b1;
                if (first_reg) begin
                  ptr_reg <= sh_reg;
                end else begin
                  wd_reg <= sh_reg; stb_reg <= 1'b1;
                end
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (rw_reg) begin
                st_reg <= S_RDATA; sh_reg <= bus.rd_data; drv_reg <= ~bus.rd_data[7];
              end else begin
                st_reg <= S_WDATA; drv_reg <= 1'b0;
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              st_reg <= S_WDATA; drv_reg <= 1'b0; cnt_reg <= 4'h0;
              first_reg <= 1'b0;
              if (!first_reg) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          S_RDATA: begin
            if (scl_fall) begin
              cnt_reg <= cnt_reg + 4'h1;
              sh_reg  <= {sh_reg[6:0], 1'b0};
              drv_reg <= (cnt_reg == 4'h7) ? 1'b0 : ~sh_reg[6];
              if (cnt_reg == 4'h7) begin
                st_reg <= S_RACK;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              nack_reg <= bus.sda;
            end else if (scl_fall) begin
              if (nack_reg) begin
                st_reg <= S_IDLE;
              end else begin
                cnt_reg <= 4'h0; ptr_reg <= ptr_reg + 8'h01;
                st_reg <= S_AACK; rw_reg <= 1'b1;
              end
            end
          end
          default: st_reg <= S_IDLE;
        endcase
      end
    end
  end

endmodule // ecl_sec_resp

// ### dv/ecl_eeprom.sv
// Purpose: Serial EEPROM model for the loader's configuration fetch.
// Assumes: The data line has a pull-up, so a released line reads high.
// Notes:   The bench may order a refusal of every written byte.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// EEPROM model
// ----------------------------------------------------------------------
module ecl_eeprom (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] mem0,
  input  wire logic [7:0] mem1,
  input  wire logic       nack_wr,
  output logic            sda_lo = 1'b0
);
  logic [7:0] sh_reg = 8'h00;
  logic       act    = 1'b0;
  logic       sel    = 1'b0;
  logic       rd     = 1'b0;
  int         bit_n  = 0;
  int         n_byte = 0;

  always @(negedge sda) if (scl) begin
    act = 1'b1;
    sel = 1'b1;
    rd = 1'b0;
    bit_n = 0;
    n_byte = 0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (bit_n < 8) sh_reg = {sh_reg[6:0], sda};
    bit_n = (bit_n == 8) ? 0 : bit_n + 1;
    if (bit_n == 0) n_byte++;
    if (bit_n == 8 && n_byte == 0) begin
      sel = (sh_reg[7:1] == ecl_pkg::EE_WR_ADDR[7:1]);
      rd = sh_reg[0];
    end
  end
  // Data only in the two read slots, so the stop after the last byte is never blocked.
  always @(negedge scl) begin
    sda_lo = 1'b0;
    if (act && sel && bit_n == 8 && !(rd && n_byte > 0)) sda_lo = !nack_wr;
    else if (act && sel && rd && bit_n < 8 && n_byte inside {1, 2})
      sda_lo = !(n_byte == 1 ? mem0[7 - bit_n] : mem1[7 - bit_n]);
  end
endmodule  // ecl_eeprom

// ### dv/ecl_loader_sva.sv
// Purpose: Port-level assertions for the configuration loader.
// Assumes: One clock domain; the load request stays low until the next one.
// Notes:   Bound to every instance of the loader.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module ecl_loader_sva #(
  parameter int LOAD_CYC = ecl_pkg::LOAD_CYC
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       mode_primary,
  input wire logic [2:0] bus_id_strap,
  input wire logic       load_req_n,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_n,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       cfg_done_n,
  input wire logic       load_failed,
  input wire logic [4:0] boost_level_index,
  input wire logic [2:0] flat_gain_sel
);
  int req_cnt_reg;
  int lo_cnt_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Both counters saturate so a long idle spell cannot wrap them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) req_cnt_reg <= 0;
    else if ($fell(load_req_n)) req_cnt_reg <= 0;
    else if (req_cnt_reg < LOAD_CYC + 64) req_cnt_reg <= req_cnt_reg + 1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lo_cnt_reg <= 0;
    else if (scl_oe_n) lo_cnt_reg <= 0;
    else if (lo_cnt_reg < 1000) lo_cnt_reg <= lo_cnt_reg + 1;
  end

  a_reset_vals: assert property ($rose(rst_n) |-> cfg_done_n && scl_oe_n && sda_oe_n
    && !load_failed && boost_level_index == ecl_pkg::BOOST_RST
    && flat_gain_sel == ecl_pkg::FLAT_RST) else $error("outputs not at reset values");
  a_done_timer: assert property ($fell(cfg_done_n) |-> req_cnt_reg >= LOAD_CYC)
    else $error("done flag before the load time");
  a_done_hold: assert property ($rose(cfg_done_n) |-> req_cnt_reg <= 8)
    else $error("done flag dropped without a request");
  a_done_clear: assert property ($fell(load_req_n) |-> ##[1:8] cfg_done_n)
    else $error("done flag kept after a new request");
  a_fail_done: assert property (load_failed |-> cfg_done_n)
    else $error("done flag low after a failed load");
  a_fail_hold: assert property ($fell(load_failed) |-> req_cnt_reg <= 8)
    else $error("fail flag cleared without a request");
  a_boost_range: assert property (boost_level_index <= ecl_pkg::BOOST_MAX)
    else $error("boost index above its maximum");
  a_sec_no_clock: assert property (!mode_primary |-> scl_oe_n)
    else $error("clock driven in secondary mode");
  a_scl_low_min: assert property ($rose(scl_oe_n) |-> lo_cnt_reg >= ecl_pkg::QTR_CYC)
    else $error("clock low phase too short");
  a_pins_low: assert property (!scl_out && !sda_out)
    else $error("bus pin drives high");

  c_load_ok: cover property ($fell(cfg_done_n));
  c_load_fail: cover property ($rose(load_failed));
  c_boost_max: cover property (boost_level_index == ecl_pkg::BOOST_MAX);
endmodule  // ecl_loader_sva

bind ecl_loader ecl_loader_sva #(.LOAD_CYC(LOAD_CYC)) u_sva (
  .clk(clk), .rst_n(rst_n), .mode_primary(mode_primary), .bus_id_strap(bus_id_strap),
  .load_req_n(load_req_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cfg_done_n(cfg_done_n),
  .load_failed(load_failed), .boost_level_index(boost_level_index),
  .flat_gain_sel(flat_gain_sel));

// ### dv/eeprom_config_loader_smbus_bench.sv
// Purpose: Self-checking bench for the configuration loader.
// Assumes: Open-drain bus lines with pull-ups; the host bit-bangs the bus.
// Notes:   Load time shortened to LOAD_CYC cycles.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module eeprom_config_loader_smbus_bench;
  localparam int LOAD_CYC = 16500;
  // A quarter of 63 cycles keeps the host just under 400 kHz.
  localparam int QH = 63;
  logic       clk          = 1'b0;
  logic       rst_n        = 1'b0;
  logic       mode_primary = 1'b0;
  logic [2:0] bus_id_strap = 3'h5;
  logic       load_req_n   = 1'b1;
  logic       h_scl_lo     = 1'b0;
  logic       h_sda_lo     = 1'b0;
  logic       nack_wr      = 1'b0;
  logic [7:0] mem0         = 8'h00;
  logic [7:0] mem1         = 8'h00;
  logic       ee_sda_lo;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, cfg_done_n, load_failed;
  logic [4:0] boost_level_index;
  logic [2:0] flat_gain_sel;
  int         n_mismatch   = 0;
  int         checks       = 0;
  int         cyc          = 0;
  wire        scl = (scl_oe_n | scl_out) & !h_scl_lo;
  wire        sda = (sda_oe_n | sda_out) & !h_sda_lo & !ee_sda_lo;

  always #(ecl_pkg::CLK_PERIOD_NS / 2) clk = !clk;
  always @(posedge clk) cyc++;

  ecl_loader #(.LOAD_CYC(LOAD_CYC)) uut (
    .clk(clk), .rst_n(rst_n), .mode_primary(mode_primary), .bus_id_strap(bus_id_strap),
    .load_req_n(load_req_n), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cfg_done_n(cfg_done_n),
    .load_failed(load_failed), .boost_level_index(boost_level_index),
    .flat_gain_sel(flat_gain_sel));
  ecl_eeprom ee (.scl(scl), .sda(sda), .mem0(mem0), .mem1(mem1), .nack_wr(nack_wr),
    .sda_lo(ee_sda_lo));

  function automatic logic [6:0] sec_addr(input logic [2:0] id);
    return {ecl_pkg::SEC_ADDR_HI, id};
  endfunction
  function automatic logic [7:0] exp_boost(input logic [7:0] old, input logic [7:0] w);
    return (w <= ecl_pkg::BOOST_MAX) ? w : old;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic qw(input int n);
    repeat (n * QH) @(negedge clk);
  endtask
  // A glitch releases the clock for 50 ns in the low phase; it must not count.
  task automatic hbit(input logic b, input logic g, output logic r);
    h_sda_lo = !b;
    if (g) begin
      repeat (8) @(negedge clk);
      h_scl_lo = 1'b0;
      repeat (5) @(negedge clk);
      h_scl_lo = 1'b1;
    end
    qw(1);
    h_scl_lo = 1'b0;
    qw(1);
    r = sda;
    qw(1);
    h_scl_lo = 1'b1;
    qw(1);
  endtask
  task automatic hbyte(input logic [7:0] d, input int gb, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) hbit(d[i], i == gb, r);
    hbit(1'b1, 1'b0, r);
    ack = !r;
  endtask
  task automatic hwrite(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d0,
                        input logic [7:0] d1, input logic two, input int gb, output logic ack);
    logic k;
    h_sda_lo = 1'b1;
    qw(1);
    h_scl_lo = 1'b1;
    qw(1);
    hbyte({a, 1'b0}, -1, ack);
    hbyte(p, -1, k);
    hbyte(d0, gb, k);
    if (two) hbyte(d1, -1, k);
    h_sda_lo = 1'b1;
    qw(1);
    h_scl_lo = 1'b0;
    qw(1);
    h_sda_lo = 1'b0;
    qw(2);
  endtask

  initial begin
    logic       a;
    logic [6:0] ad;
    logic [7:0] b0;
    logic [7:0] f0;
    int         t0;
    time        tr;
    void'($urandom(95387));
    do_reset();
    chk("cfg_done_n", 1, cfg_done_n);
    chk("flat_gain_sel", ecl_pkg::FLAT_RST, flat_gain_sel);
    chk("boost_level_index", ecl_pkg::BOOST_RST, boost_level_index);
    ad = sec_addr(bus_id_strap);
    b0 = 8'($urandom_range(19));
    f0 = 8'($urandom_range(7));
    hwrite(ad, ecl_pkg::REG_BOOST, b0, f0, 1'b1, 2, a);
    chk("address ack", 1, a);
    chk("boost_level_index", b0, boost_level_index);
    chk("flat_gain_sel", f0, flat_gain_sel);
    load_req_n = 1'b0;
    repeat (LOAD_CYC + 500) @(negedge clk);
    chk("cfg_done_n", 1, cfg_done_n);
    load_req_n = 1'b1;
    hwrite(ad, ecl_pkg::REG_BOOST, 8'h14, 8'h00, 1'b0, -1, a);
    chk("boost_level_index", exp_boost(b0, 8'h14), boost_level_index);
    hwrite(ad ^ 7'h01, ecl_pkg::REG_BOOST, 8'h13, 8'h00, 1'b0, -1, a);
    chk("address ack", 0, a);
    chk("boost_level_index", b0, boost_level_index);
    mode_primary = 1'b1;
    nack_wr = 1'b1;
    mem0 = 8'($urandom_range(19));
    mem1 = 8'($urandom);
    do_reset();
    load_req_n = 1'b0;
    for (int i = 0; i < 20000 && load_failed !== 1'b1; i++) @(negedge clk);
    repeat (LOAD_CYC) @(negedge clk);
    chk("load_failed", 1, load_failed);
    chk("cfg_done_n", 1, cfg_done_n);
    nack_wr = 1'b0;
    load_req_n = 1'b1;
    repeat (8) @(negedge clk);
    load_req_n = 1'b0;
    t0 = cyc;
    repeat (2) @(posedge scl);
    tr = $time;
    @(posedge scl);
    chk("scl period", 4 * ecl_pkg::QTR_CYC * ecl_pkg::CLK_PERIOD_NS, 32'($time - tr));
    for (int i = 0; i < 40000 && cfg_done_n !== 1'b0; i++) @(negedge clk);
    chk("load delay", 1, cyc - t0 >= LOAD_CYC && cyc - t0 <= LOAD_CYC + 16);
    chk("cfg_done_n", 0, cfg_done_n);
    chk("load_failed", 0, load_failed);
    chk("boost_level_index", mem0, boost_level_index);
    chk("flat_gain_sel", mem1[2:0], flat_gain_sel);
    bus_id_strap = ~bus_id_strap;
    hwrite(ad, ecl_pkg::REG_BOOST, 8'h13, 8'h00, 1'b0, -1, a);
    chk("boost_level_index", ecl_pkg::BOOST_MAX, boost_level_index);
    chk("cfg_done_n", 0, cfg_done_n);
    load_req_n = 1'b1;
    repeat (8) @(negedge clk);
    load_req_n = 1'b0;
    repeat (16) @(negedge clk);
    chk("cfg_done_n", 1, cfg_done_n);
    end_sim();
  end

  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
endmodule  // eeprom_config_loader_smbus_bench

// ### shared/ecl_pkg.sv
// Purpose: Shared constants and types for the configuration loader.
// Assumes: 100 MHz system clock.
// Notes:   Times are kept in their own units; cycle counts derive from them.

package ecl_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_KHZ       = 100000;
  localparam int SCL_M_KHZ     = 303;
  // Four phases per bit; a typical figure, so truncation is acceptable.
  localparam int QTR_CYC       = CLK_KHZ / (SCL_M_KHZ * 4);
  localparam int SPIKE_NS      = 50;
  localparam int SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_MS       = 30;
  localparam int LOAD_CYC      = LOAD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SEC_KHZ_MAX   = 400;

  // ----------------------------------------------------------------------
  // Register map of the secondary port
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_BOOST  = 8'h00;
  localparam logic [7:0] REG_FLAT   = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [4:0] BOOST_RST  = 5'h00;
  localparam logic [4:0] BOOST_MAX  = 5'h13;
  localparam logic [2:0] FLAT_RST   = 3'h5;
  // Upper bits of the secondary address; the value is arbitrary.
  localparam logic [3:0] SEC_ADDR_HI = 4'h3;

  // ----------------------------------------------------------------------
  // EEPROM read sequence
  // ----------------------------------------------------------------------
  localparam logic [7:0] EE_WR_ADDR  = 8'ha0;
  localparam logic [7:0] EE_RD_ADDR  = 8'ha1;
  localparam logic [7:0] EE_OFFSET   = 8'h00;
  localparam logic [2:0] TOK_LAST    = 3'h7;
  localparam logic [3:0] BYTE_BITS   = 4'h9;

  typedef enum logic [2:0] {
    TK_START, TK_WR, TK_RD_ACK, TK_RD_NACK, TK_STOP
  } ecl_tok_t;

endpackage

// ### shared/ecl_sec_if.sv
// Purpose: Carries filtered bus levels and register accesses between the
//          loader top and its secondary bus responder.
// Assumes: Single clock domain.
// Notes:   None.
`timescale 1ns/1ps

interface ecl_sec_if;
  logic       scl;
  logic       sda;
  logic [6:0] dev_addr;
  logic       sda_low;
  logic       busy;
  logic       wr_stb;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;
  logic [7:0] rd_ptr;
  logic [7:0] rd_data;

  modport resp (
    input  scl, sda, dev_addr, rd_data,
    output sda_low, busy, wr_stb, wr_ptr, wr_data, rd_ptr
  );
  modport host (
    output scl, sda, dev_addr, rd_data,
    input  sda_low, busy, wr_stb, wr_ptr, wr_data, rd_ptr
  );
endinterface
